/* File: shared/sync_link_pkg.sv */
// Constants, register map and types shared by both ends of the clocked serial link.
package sync_link_pkg;

	// Bus address width and own register offsets.
	localparam int         ADDR_W          = 8;
	typedef logic [ADDR_W-1:0] addr_t;
	localparam addr_t      CONTROL_OFFSET  = 8'h00;
	localparam addr_t      DIVISOR_OFFSET  = 8'h04;
	localparam addr_t      HOLDING_OFFSET  = 8'h08;
	localparam addr_t      STATUS_OFFSET   = 8'h0C;

	// Field positions inside the control register.
	localparam int         SYNC_MODE_BIT   = 0;
	localparam int         MASTER_BIT      = 1;
	localparam int         ENABLE_BIT      = 2;
	localparam int         SINGLE_RX_BIT   = 3;
	localparam int         CONT_RX_BIT     = 4;
	localparam int         HIGH_SPEED_BIT  = 5;
	localparam int         NINE_BIT_BIT    = 6;
	localparam int         NINTH_DATA_BIT  = 7;

	// Field positions inside the status register.
	localparam int         HOLD_FULL_BIT   = 0;
	localparam int         SHIFT_BUSY_BIT  = 1;
	localparam int         TX_MODE_BIT     = 2;

	// Reset values and character sizes.
	localparam logic [7:0] CONTROL_RESET   = 8'h00;
	localparam logic [7:0] DIVISOR_RESET   = 8'h00;
	localparam logic [3:0] BITS_EIGHT      = 4'h8;
	localparam logic [3:0] BITS_NINE       = 4'h9;
	localparam logic [3:0] BITS_ONE        = 4'h1;

	// Half of the mode factor: sync 4, async high speed 16, async low speed 64.
	localparam logic [5:0] HALF_SYNC       = 6'h02;
	localparam logic [5:0] HALF_ASYNC_HIGH = 6'h08;
	localparam logic [5:0] HALF_ASYNC_LOW  = 6'h20;

	// Transmit sequencer states, Gray coded along idle, lead, trail.
	typedef enum logic [1:0] {
		TX_IDLE  = 2'b00,
		TX_LEAD  = 2'b01,
		TX_TRAIL = 2'b11
	} tx_state_t;

	// Returns the pclk count of one half bit period: factor * (n + 1) / 2.
	function automatic logic [15:0] half_period(input logic [7:0] divisor,
		input logic sync_mode, input logic high_speed);
		logic [5:0] half;
		half = sync_mode ? HALF_SYNC : (high_speed ? HALF_ASYNC_HIGH : HALF_ASYNC_LOW);
		return 16'({8'h00, divisor} + 16'h0001) * 16'({10'h000, half});
	endfunction

endpackage

/* File: shared/sync_link_if.sv */
// Two-wire clocked serial link: master clock line and shared data line.
`timescale 1ns/1ps
interface sync_link_if;
	logic clock_pin_out;
	logic clock_pin_oe;
	logic data_pin_out;
	logic data_pin_oe;
	logic slave_data_out;
	logic slave_data_oe;
	logic clock_level;
	logic data_level;

	// Resolves the wires: clock idles low, data idles high through a pull-up.
	assign clock_level = clock_pin_oe ? clock_pin_out : 1'b0;
	assign data_level  = data_pin_oe ? data_pin_out : (slave_data_oe ? slave_data_out : 1'b1);

	modport master (
		output clock_pin_out,
		output clock_pin_oe,
		output data_pin_out,
		output data_pin_oe,
		input  clock_level,
		input  data_level
	);

	modport slave (
		output slave_data_out,
		output slave_data_oe,
		input  clock_level,
		input  data_level
	);
endinterface

/* File: verilog/sync_master_tx.sv */
// Clocked serial master transmitter with APB register access.
// Summary of operation
// - One shared data line, one clock, half-duplex.
// - No start or stop bits are sent.
// - Master makes the clock for all slaves.
// - Sync, master and enable bits select operation.
// - Transmit only when both receive enables clear.
// - Software disables shared display segments first.
// - Clock pin driver on in sync master.
// - Data changes on leading clock edge.
// - One clock cycle per data bit only.
// - Transmit drives data and clock pins.
// - Writing the holding register starts sending.
// - New character waits while shifter is busy.
// - Empty shifter loads holding register at once.
// - Each bit holds until next leading edge.
// - Shift register is not software visible.
// - Divisor 25 at 4 MHz gives 38461.
// - Rate is clock over factor times (n+1).
// - Ninth bit loaded first, nine bits shifted.
`timescale 1ns/1ps
module sync_master_tx (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire sync_link_pkg::addr_t paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	sync_link_if.master               link
);
	import sync_link_pkg::*;

	logic [7:0]  control;
	logic [7:0]  next_control;
	logic [7:0]  divisor;
	logic [7:0]  next_divisor;
	logic [8:0]  holding;
	logic [8:0]  next_holding;
	logic        holding_full;
	logic        next_holding_full;
	logic [8:0]  shifter;
	logic [8:0]  next_shifter;
	logic [3:0]  bits_left;
	logic [3:0]  next_bits_left;
	logic [15:0] half_count;
	logic [15:0] next_half_count;
	logic [15:0] reload;
	tx_state_t   state;
	tx_state_t   next_state;
	logic        clock_out;
	logic        next_clock_out;
	logic        data_out;
	logic        next_data_out;
	logic [31:0] next_prdata;
	logic        next_pslverr;
	logic        master_on;
	logic        tx_mode;
	logic        setup;
	logic        access;
	logic        mapped;

	////////////////////////////////////////////////////////////////////////////////
	// Mode decode and pin drivers.

	// Master operation needs sync, master select and port enable all set.
	assign master_on = control[SYNC_MODE_BIT] & control[MASTER_BIT] & control[ENABLE_BIT];
	// Any receive enable turns the port away from transmit.
	assign tx_mode   = master_on & ~control[SINGLE_RX_BIT] & ~control[CONT_RX_BIT];

	// The clock driver is on in any master mode, data only when transmitting.
	assign link.clock_pin_oe  = master_on;
	assign link.clock_pin_out = clock_out;
	assign link.data_pin_oe   = tx_mode;
	assign link.data_pin_out  = data_out;

	// Half bit period from the divisor and the mode factor.
	assign reload = half_period(divisor, control[SYNC_MODE_BIT], control[HIGH_SPEED_BIT])
		- 16'h0001;

	// The slave never waits.
	assign pready = 1'b1;
	assign setup  = psel & ~penable;
	assign access = psel & penable;
	assign mapped = (paddr == CONTROL_OFFSET) | (paddr == DIVISOR_OFFSET)
		| (paddr == HOLDING_OFFSET) | (paddr == STATUS_OFFSET);

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic for the sequencer and the register file.

	// The sequencer runs first so that a bus write in the same cycle wins.
	always_comb begin
		next_control      = control;
		next_divisor      = divisor;
		next_holding      = holding;
		next_holding_full = holding_full;
		next_shifter      = shifter;
		next_bits_left    = bits_left;
		next_half_count   = half_count;
		next_state        = state;
		next_clock_out    = clock_out;
		next_data_out     = data_out;
		next_prdata       = prdata;
		next_pslverr      = pslverr;

		if (!tx_mode) begin
			// Leaving transmit mode drops the character in flight.
			next_state     = TX_IDLE;
			next_clock_out = 1'b0;
			next_bits_left = 4'h0;
			if (!control[ENABLE_BIT]) begin
				next_holding_full = 1'b0;
			end
		end else begin
			case (state)
				TX_IDLE: begin
					// Clock stays at its idle level with no edges.
					next_clock_out = 1'b0;
				end
				TX_LEAD: begin
					if (half_count == 16'h0000) begin
						// Trailing edge: the slave samples here.
						next_clock_out  = 1'b0;
						next_half_count = reload;
						next_state      = TX_TRAIL;
					end else begin
						next_half_count = half_count - 16'h0001;
					end
				end
				TX_TRAIL: begin
					if (half_count != 16'h0000) begin
						next_half_count = half_count - 16'h0001;
					end else if (bits_left > BITS_ONE) begin
						// Leading edge with the next data bit.
						next_shifter    = {1'b0, shifter[8:1]};
						next_data_out   = shifter[1];
						next_bits_left  = bits_left - 4'h1;
						next_clock_out  = 1'b1;
						next_half_count = reload;
						next_state      = TX_LEAD;
					end else begin
						// Last bit done; no extra clock cycle follows.
						next_bits_left = 4'h0;
						next_state     = TX_IDLE;
					end
				end
				default: begin
					next_state     = TX_IDLE;
					next_clock_out = 1'b0;
				end
			endcase

			// Load the shifter as soon as it is empty and a character waits.
			if (holding_full && (next_state == TX_IDLE)) begin
				next_shifter      = holding;
				next_data_out     = holding[0];
				next_bits_left    = control[NINE_BIT_BIT] ? BITS_NINE : BITS_EIGHT;
				next_clock_out    = 1'b1;
				next_half_count   = reload;
				next_state        = TX_LEAD;
				next_holding_full = 1'b0;
			end
		end

		// Read data and error are prepared in the setup cycle.
		if (setup) begin
			next_pslverr = ~mapped;
			next_prdata  = 32'h0000_0000;
			if (!pwrite) begin
				case (paddr)
					CONTROL_OFFSET: next_prdata = {24'h000000, control};
					DIVISOR_OFFSET: next_prdata = {24'h000000, divisor};
					HOLDING_OFFSET: next_prdata = {23'h000000, holding};
					STATUS_OFFSET: begin
						// Shifter contents stay hidden; only busy is shown.
						next_prdata[HOLD_FULL_BIT]  = holding_full;
						next_prdata[SHIFT_BUSY_BIT] = (state != TX_IDLE);
						next_prdata[TX_MODE_BIT]    = tx_mode;
					end
					default: next_prdata = 32'h0000_0000;
				endcase
			end
		end

		// Writes take effect at the access edge.
		if (access && pwrite) begin
			case (paddr)
				CONTROL_OFFSET: next_control = pwdata[7:0];
				DIVISOR_OFFSET: next_divisor = pwdata[7:0];
				HOLDING_OFFSET: begin
					if (control[ENABLE_BIT]) begin
						// The ninth bit is taken from control at write time.
						next_holding      = {control[NINTH_DATA_BIT], pwdata[7:0]};
						next_holding_full = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State registers.

	// Registers the next values; reset leaves the port disabled and idle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control      <= CONTROL_RESET;
			divisor      <= DIVISOR_RESET;
			holding      <= 9'h000;
			holding_full <= 1'b0;
			shifter      <= 9'h000;
			bits_left    <= 4'h0;
			half_count   <= 16'h0000;
			state        <= TX_IDLE;
			clock_out    <= 1'b0;
			data_out     <= 1'b0;
			prdata       <= 32'h0000_0000;
			pslverr      <= 1'b0;
		end else begin
			control      <= next_control;
			divisor      <= next_divisor;
			holding      <= next_holding;
			holding_full <= next_holding_full;
			shifter      <= next_shifter;
			bits_left    <= next_bits_left;
			half_count   <= next_half_count;
			state        <= next_state;
			clock_out    <= next_clock_out;
			data_out     <= next_data_out;
			prdata       <= next_prdata;
			pslverr      <= next_pslverr;
		end
	end

endmodule

/* File: verilog/sync_slave_rx.sv */
// Clocked serial slave receiver driven by the master's clock line.
`timescale 1ns/1ps
module sync_slave_rx (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       slave_enable,
	input  wire logic       nine_bit_mode,
	output logic      [8:0] rx_data,
	output logic            rx_valid,
	sync_link_if.slave      link
);
	import sync_link_pkg::*;

	logic       clock_meta;
	logic       clock_sync;
	logic       clock_prev;
	logic       data_meta;
	logic       data_sync;
	logic [8:0] shifter;
	logic [8:0] next_shifter;
	logic [3:0] count;
	logic [3:0] next_count;
	logic [8:0] next_rx_data;
	logic       next_rx_valid;
	logic [3:0] target;

	// Receive only: the slave never drives the shared data line.
	assign link.slave_data_out = 1'b0;
	assign link.slave_data_oe  = 1'b0;
	assign target              = nine_bit_mode ? BITS_NINE : BITS_EIGHT;

	////////////////////////////////////////////////////////////////////////////////
	// Shifts one bit in at each trailing edge of the external clock.

	// Data enters at the top so the first bit ends up lowest.
	always_comb begin
		next_shifter  = shifter;
		next_count    = count;
		next_rx_data  = rx_data;
		next_rx_valid = 1'b0;
		if (!slave_enable) begin
			next_count = 4'h0;
		end else if (clock_prev && !clock_sync) begin
			next_shifter = {data_sync, shifter[8:1]};
			if (count + 4'h1 == target) begin
				// Character complete; no framing bits are expected.
				next_rx_data  = nine_bit_mode ? next_shifter : {1'b0, next_shifter[8:1]};
				next_rx_valid = 1'b1;
				next_count    = 4'h0;
			end else begin
				next_count = count + 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Synchronisers and state registers.

	// Both pins pass two flip-flops with equal delay before use.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_meta <= 1'b0;
			clock_sync <= 1'b0;
			clock_prev <= 1'b0;
			data_meta  <= 1'b1;
			data_sync  <= 1'b1;
			shifter    <= 9'h000;
			count      <= 4'h0;
			rx_data    <= 9'h000;
			rx_valid   <= 1'b0;
		end else begin
			clock_meta <= link.clock_level;
			clock_sync <= clock_meta;
			clock_prev <= clock_sync;
			data_meta  <= link.data_level;
			data_sync  <= data_meta;
			shifter    <= next_shifter;
			count      <= next_count;
			rx_data    <= next_rx_data;
			rx_valid   <= next_rx_valid;
		end
	end

endmodule

/* File: test/sync_link_monitor.sv */
// Concurrent checks on the wires of the clocked serial link.
`timescale 1ns/1ps
module sync_link_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clock_pin_out,
	input wire logic clock_pin_oe,
	input wire logic data_pin_out,
	input wire logic data_pin_oe,
	input wire logic slave_data_oe
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////////////////
	// Data may only move together with a rising link clock.
	data_on_lead_a: assert property (
		$changed(data_pin_out) && $past(data_pin_oe) && data_pin_oe |-> $rose(clock_pin_out))
		else $error("data moved away from a leading clock edge");
	bit_hold_a: assert property (
		clock_pin_out && $past(clock_pin_out) |-> $stable(data_pin_out))
		else $error("data moved while the clock was high");

	// Pin drivers follow the master transmit configuration.
	clock_drive_a: assert property ($rose(clock_pin_out) |-> clock_pin_oe)
		else $error("clock rose without its driver");
	data_drive_a: assert property (data_pin_oe |-> clock_pin_oe)
		else $error("data driven without the clock driver");
	half_duplex_a: assert property (data_pin_oe |-> !slave_data_oe)
		else $error("both ends drive the data line");

	// Each half period lasts at least two cycles, the high half at most 512.
	high_min_a: assert property (
		$rose(clock_pin_out) |=> clock_pin_out || !clock_pin_oe)
		else $error("clock high half too short");
	low_min_a: assert property (
		$fell(clock_pin_out) && clock_pin_oe |=> !clock_pin_out)
		else $error("clock low half too short");
	high_max_a: assert property ($rose(clock_pin_out) |-> ##[1:512] !clock_pin_out)
		else $error("clock high half too long");
	stop_on_off_a: assert property ($fell(clock_pin_oe) |=> !clock_pin_out)
		else $error("clock kept running after disable");
endmodule

/* File: test/tb_top.sv */
// Self-checking bench joining the link master to a slave receiver.
`timescale 1ns/1ps
module tb_top;
	import sync_link_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	addr_t       paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic        slave_enable, nine_bit_mode, rx_valid;
	logic        lvl_q = 1'b0;
	logic [8:0]  rx_data;
	logic [7:0]  div, c0, c1;
	int          err_total, n_compared, seed, r0;
	int          rises = 0, cyc = 0, last_rise = 0, period = 0;
	sync_link_if link ();

	sync_master_tx u_sync_master_tx (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.master));
	sync_slave_rx u_sync_slave_rx (.pclk(pclk), .presetn(presetn),
		.slave_enable(slave_enable), .nine_bit_mode(nine_bit_mode),
		.rx_data(rx_data), .rx_valid(rx_valid), .link(link.slave));
	sync_link_monitor u_sync_link_monitor (.pclk(pclk), .presetn(presetn),
		.clock_pin_out(link.clock_pin_out), .clock_pin_oe(link.clock_pin_oe),
		.data_pin_out(link.data_pin_out), .data_pin_oe(link.data_pin_oe),
		.slave_data_oe(link.slave_data_oe));

	////////////////////////////////////////////////////////////////////////
	// Free-running system clock.
	always #50 pclk = ~pclk;

	// Counts link clock rises and measures the spacing of the last two.
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		lvl_q <= link.clock_level;
		if (link.clock_level && !lvl_q) begin
			rises <= rises + 1;
			period <= cyc - last_rise;
			last_rise <= cyc;
		end
	end

	// Compares one value and reports a mismatch at once.
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_compared++;
		if (seen !== want) begin
			err_total++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask

	// Link clock period in pclk cycles for clocked mode: four times (divisor plus one).
	function automatic int bit_period(input logic [7:0] n);
		return 4 * (int'(n) + 1);
	endfunction

	// One APB transfer; waits for pready and keeps read data and error.
	// Only the watchdog ends a wait that never sees pready.
	task automatic apb(input logic wr, input addr_t a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Waits for a received character and checks it and the clock count.
	// A character that never arrives is caught by the watchdog.
	task automatic expect_char(input logic [8:0] want, input int bits);
		while (rx_valid !== 1'b1) begin
			@(posedge pclk);
		end
		check(32'(rx_data), 32'(want));
		if (bits > 0)
			check(rises - r0, bits);
		@(posedge pclk);
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Cuts a hung run short.
	initial begin
		#5000000;
		err_total++;
		finish_test();
	end

	// Main sequence of scenarios.
	initial begin
		seed = 32'h5fc5f46e;
		{pclk, presetn, psel, penable, pwrite} = '0;
		{paddr, pwdata, slave_enable, nine_bit_mode} = '0;
		{err_total, n_compared} = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, CONTROL_OFFSET, 32'h0);
		check(rdat, 32'(CONTROL_RESET));
		check(32'(rerr), 32'h0);
		apb(1'b0, DIVISOR_OFFSET, 32'h0);
		check(rdat, 32'(DIVISOR_RESET));
		apb(1'b0, 8'h10, 32'h0);
		check(32'(rerr), 32'h1);
		apb(1'b1, HOLDING_OFFSET, 32'h5A);
		apb(1'b0, STATUS_OFFSET, 32'h0);
		check(rdat, 32'h0);
		div = 8'($random(seed)) & 8'h03;
		apb(1'b1, DIVISOR_OFFSET, 32'(div));
		// The shared pins are taken for the link only once display use is off.
		apb(1'b1, CONTROL_OFFSET, 32'h07);
		slave_enable <= 1'b1;
		apb(1'b0, STATUS_OFFSET, 32'h0);
		check(rdat, 32'h4);
		for (int i = 0; i < 6; i++) begin
			c0 = (i == 0) ? 8'h01 : (i == 1) ? 8'h80 : 8'($random(seed));
			r0 = rises;
			apb(1'b1, HOLDING_OFFSET, 32'(c0));
			expect_char({1'b0, c0}, 8);
			check(period, bit_period(div));
		end
		c0 = 8'($random(seed));
		c1 = 8'($random(seed));
		r0 = rises;
		apb(1'b1, HOLDING_OFFSET, 32'(c0));
		apb(1'b1, HOLDING_OFFSET, 32'(c1));
		apb(1'b0, STATUS_OFFSET, 32'h0);
		check(rdat, 32'h7);
		expect_char({1'b0, c0}, 0);
		expect_char({1'b0, c1}, 16);
		nine_bit_mode <= 1'b1;
		apb(1'b1, CONTROL_OFFSET, 32'hC7);
		c0 = 8'($random(seed));
		r0 = rises;
		apb(1'b1, HOLDING_OFFSET, 32'(c0));
		expect_char({1'b1, c0}, 9);
		nine_bit_mode <= 1'b0;
		apb(1'b0, HOLDING_OFFSET, 32'h0);
		check(rdat, 32'({1'b1, c0}));
		// Pin enables follow the control word at the access edge of the write.
		apb(1'b1, CONTROL_OFFSET, 32'h0F);
		@(posedge pclk);
		check(32'(link.data_pin_oe), 32'h0);
		check(32'(link.clock_pin_oe), 32'h1);
		apb(1'b1, CONTROL_OFFSET, 32'h17);
		@(posedge pclk);
		check(32'(link.data_pin_oe), 32'h0);
		check(32'(link.clock_pin_oe), 32'h1);
		apb(1'b1, CONTROL_OFFSET, 32'h05);
		@(posedge pclk);
		check(32'(link.clock_pin_oe), 32'h0);
		check(32'(link.data_pin_oe), 32'h0);
		apb(1'b1, CONTROL_OFFSET, 32'h07);
		apb(1'b1, HOLDING_OFFSET, 32'hA5);
		repeat (6) @(posedge pclk);
		apb(1'b1, CONTROL_OFFSET, 32'h00);
		repeat (3) @(posedge pclk);
		check(32'(link.clock_level), 32'h0);
		apb(1'b0, STATUS_OFFSET, 32'h0);
		check(rdat, 32'h0);
		slave_enable <= 1'b0;
		apb(1'b1, CONTROL_OFFSET, 32'h07);
		slave_enable <= 1'b1;
		c0 = 8'($random(seed));
		r0 = rises;
		apb(1'b1, HOLDING_OFFSET, 32'(c0));
		expect_char({1'b0, c0}, 8);
		check(32'(link.clock_level), 32'h0);
		finish_test();
	end
endmodule
